// ---- include/adcpo_cfg.svh ----
`ifndef ADCPO_CFG_SVH
`define ADCPO_CFG_SVH

// ****************************************
// Widths
// ****************************************
`define ADCPO_DATA_W 12
`define ADCPO_AIN_W 14
`define ADCPO_MSB_POS 11

// ****************************************
// Output codes and reset values
// ****************************************
`define ADCPO_CODE_UNDER 12'h000
`define ADCPO_CODE_OVER 12'hfff
`define ADCPO_BUS_RST 12'h000

// ****************************************
// Timing counts, in conversion clock cycles
// ****************************************
`define ADCPO_PIPE_DEPTH 3
`define ADCPO_SYNC_STAGES 2

`endif

// ---- include/adcpo_pkg.sv ----
package adcpo_pkg;

   // Four-level select pin, digitised as 2 bits, lowest level first
   typedef enum logic [1:0] {
      ADCPO_LVL_GND,
      ADCPO_LVL_THIRD,
      ADCPO_LVL_TWO_THIRDS,
      ADCPO_LVL_TOP
   } adcpo_level_t;

   typedef enum logic [1:0] {
      ADCPO_PWR_RUN,
      ADCPO_PWR_DOWN,
      ADCPO_PWR_WAKE
   } adcpo_pwr_t;

endpackage

// ---- core/adcpo_sync.sv ----
`timescale 1ns/1ps
module adcpo_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] hold_r;
   logic [W-1:0] hold_nxt;

   // First stage feeds only the second stage
   always_comb begin
      meta_nxt = d;
      hold_nxt = meta_r;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         hold_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign q = hold_r;
endmodule

// ---- core/adcpo_quant.sv ----
`timescale 1ns/1ps
`include "adcpo_cfg.svh"
module adcpo_quant #(
   parameter int AIN_W = `ADCPO_AIN_W,
   parameter int DATA_W = `ADCPO_DATA_W
) (
   input wire logic signed [AIN_W-1:0] sample,
   output logic [DATA_W-1:0] code,
   output logic under,
   output logic over
);
   localparam logic signed [AIN_W:0] MID = (AIN_W+1)'(2**(DATA_W-1));
   localparam logic signed [AIN_W:0] TOP = (AIN_W+1)'(2**DATA_W - 1);
   logic signed [AIN_W:0] ext;

   // Offset binary first; the output stage flips the MSB for two's compl.
   always_comb begin
      ext = $signed({sample[AIN_W-1], sample}) + MID;
      under = 1'b0;
      over = 1'b0;
      code = ext[DATA_W-1:0];
      if (ext < 0) begin
         under = 1'b1;
         code = `ADCPO_CODE_UNDER; // [R07]
      end else if (ext > TOP) begin
         over = 1'b1;
         code = `ADCPO_CODE_OVER; // [R07]
      end
   end
endmodule

// ---- core/adcpo_top.sv ----
// Functional notes
// R01 - The analog input is sampled on each rising edge of conversion clock.
// R02 - Power-down select high stops conversion; low runs normally.
// R03 - Results leave as a 12-bit word, bit 0 the LSB and bit 11 the MSB.
// R04 - The output bus changes only at the falling edge of the strobe; the code also moves it with the strobe idle at power-down and wake-up.
// R05 - The data-ready strobe runs at exactly the conversion clock rate.
// R06 - The four-level select picks coding and duty cycle stabilizer.
// R07 - Inputs below range give code 0, inputs above give code 4095; with two's complement coding the bus gives 2048 and 2047.
// R08 - Capture logic latches each word on the strobe's rising edge.
`timescale 1ns/1ps
`include "adcpo_cfg.svh"
module adcpo_top #(
   parameter int AIN_W = `ADCPO_AIN_W,
   parameter int DATA_W = `ADCPO_DATA_W,
   parameter int PIPE_DEPTH = `ADCPO_PIPE_DEPTH
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic conv_clk,
   input wire logic power_down_select,
   input wire logic [1:0] format_stabilizer_select,
   input wire logic signed [AIN_W-1:0] analog_in,
   output logic [DATA_W-1:0] sample_output_bus,
   output logic data_ready_strobe,
   output logic duty_cycle_stabilizer,
   output logic powered_down,
   output logic range_event
);
   localparam int PW = DATA_W + 2;
   localparam int CW = $clog2(PIPE_DEPTH + 1);
   localparam logic [CW-1:0] WAKE_LAST = CW'(PIPE_DEPTH - 1);

   // ****************************************
   // Control pins, system clock domain
   // ****************************************
   logic [2:0] pin_s;
   logic pd_r;
   logic pd_nxt;
   logic twos_r;
   logic twos_nxt;
   logic dcs_r;
   logic dcs_nxt;
   adcpo_pkg::adcpo_level_t lvl;

   adcpo_sync #(.W(3)) u_pin_sync (
      .clock(clock),
      .nrst(nrst),
      .d({power_down_select, format_stabilizer_select}),
      .q(pin_s)
   );

   always_comb begin
      lvl = adcpo_pkg::adcpo_level_t'(pin_s[1:0]);
      pd_nxt = pin_s[2];
      twos_nxt = 1'b0;
      dcs_nxt = 1'b0;
      case (lvl)
         adcpo_pkg::ADCPO_LVL_TOP: begin
            twos_nxt = 1'b1; // [R06]
         end
         adcpo_pkg::ADCPO_LVL_TWO_THIRDS: begin
            twos_nxt = 1'b1; // [R06]
            dcs_nxt = 1'b1; // [R06]
         end
         adcpo_pkg::ADCPO_LVL_THIRD: begin
            dcs_nxt = 1'b1; // [R06]
         end
         default: begin
            twos_nxt = 1'b0; // [R06]
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pd_r <= 1'b0;
         twos_r <= 1'b0;
         dcs_r <= 1'b0;
      end else begin
         pd_r <= pd_nxt;
         twos_r <= twos_nxt;
         dcs_r <= dcs_nxt;
      end
   end

   // ****************************************
   // Reset release into the conversion domain
   // ****************************************
   logic crst_meta_r;
   logic crst_r;

   // Asserts at once, releases on conversion clock edges
   always_ff @(posedge conv_clk or negedge nrst) begin
      if (!nrst) begin
         crst_meta_r <= 1'b0;
         crst_r <= 1'b0;
      end else begin
         crst_meta_r <= 1'b1;
         crst_r <= crst_meta_r;
      end
   end

   // ****************************************
   // Control levels into the conversion domain
   // ****************************************
   logic [2:0] ctl_c;
   logic c_pd;
   logic c_twos;

   // Selects are static straps; a change may mix one word's coding
   adcpo_sync #(.W(3)) u_ctl_sync (
      .clock(conv_clk),
      .nrst(crst_r),
      .d({pd_r, twos_r, dcs_r}),
      .q(ctl_c)
   );

   assign c_pd = ctl_c[2];
   assign c_twos = ctl_c[1];

   // ****************************************
   // Sampling and conversion pipeline
   // ****************************************
   logic [DATA_W-1:0] q_code;
   logic q_under;
   logic q_over;
   logic [PW-1:0] pipe_r [PIPE_DEPTH];
   logic [PW-1:0] pipe_nxt [PIPE_DEPTH];
   adcpo_pkg::adcpo_pwr_t pwr_r;
   adcpo_pkg::adcpo_pwr_t pwr_nxt;
   logic [CW-1:0] wake_r;
   logic [CW-1:0] wake_nxt;
   logic [DATA_W-1:0] bus_r;
   logic [DATA_W-1:0] bus_nxt;
   logic run_r;
   logic run_nxt;
   logic dcs_out_r;
   logic dcs_out_nxt;
   logic tog_r;
   logic tog_nxt;
   logic sleep_r;
   logic sleep_nxt;
   logic [PW-1:0] tail;

   adcpo_quant #(.AIN_W(AIN_W), .DATA_W(DATA_W)) u_quant (
      .sample(analog_in),
      .code(q_code),
      .under(q_under),
      .over(q_over)
   );

   assign tail = pipe_r[PIPE_DEPTH-1];

   always_comb begin
      pwr_nxt = pwr_r;
      wake_nxt = wake_r;
      bus_nxt = bus_r;
      run_nxt = run_r;
      tog_nxt = tog_r;
      dcs_out_nxt = ctl_c[0];
      sleep_nxt = 1'b0;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
         pipe_nxt[i] = pipe_r[i];
      end
      case (pwr_r)
         adcpo_pkg::ADCPO_PWR_RUN: begin
            pipe_nxt[0] = {q_over, q_under, q_code}; // [R01]
            for (int i = 1; i < PIPE_DEPTH; i++) begin
               pipe_nxt[i] = pipe_r[i-1];
            end
            // Strobe falls at this edge except the first after wake-up, so the bus moves with it
            bus_nxt = tail[DATA_W-1:0]
               ^ {c_twos, {(DATA_W-1){1'b0}}}; // [R03] [R04]
            run_nxt = 1'b1; // [R05]
            if (tail[DATA_W+1] || tail[DATA_W]) begin
               tog_nxt = ~tog_r;
            end
            if (c_pd) begin
               pwr_nxt = adcpo_pkg::ADCPO_PWR_DOWN; // [R02]
               run_nxt = 1'b0;
            end
         end
         adcpo_pkg::ADCPO_PWR_DOWN: begin
            // Pipeline frozen to save switching power
            run_nxt = 1'b0; // [R02]
            bus_nxt = `ADCPO_BUS_RST;
            sleep_nxt = 1'b1;
            if (!c_pd) begin
               pwr_nxt = adcpo_pkg::ADCPO_PWR_WAKE;
               wake_nxt = '0;
               sleep_nxt = 1'b0;
            end
         end
         adcpo_pkg::ADCPO_PWR_WAKE: begin
            // Refill so no stale word leaves after wake-up
            pipe_nxt[0] = {q_over, q_under, q_code}; // [R01]
            for (int i = 1; i < PIPE_DEPTH; i++) begin
               pipe_nxt[i] = pipe_r[i-1];
            end
            wake_nxt = wake_r + CW'(1);
            if (c_pd) begin
               pwr_nxt = adcpo_pkg::ADCPO_PWR_DOWN; // [R02]
            end else if (wake_r == WAKE_LAST) begin
               pwr_nxt = adcpo_pkg::ADCPO_PWR_RUN;
            end
         end
         default: begin
            pwr_nxt = adcpo_pkg::ADCPO_PWR_DOWN;
            run_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge conv_clk or negedge crst_r) begin
      if (!crst_r) begin
         pwr_r <= adcpo_pkg::ADCPO_PWR_WAKE;
         wake_r <= '0;
         bus_r <= `ADCPO_BUS_RST;
         run_r <= 1'b0;
         tog_r <= 1'b0;
         dcs_out_r <= 1'b0;
         sleep_r <= 1'b0;
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_r[i] <= '0;
         end
      end else begin
         pwr_r <= pwr_nxt;
         wake_r <= wake_nxt;
         bus_r <= bus_nxt;
         run_r <= run_nxt;
         tog_r <= tog_nxt;
         dcs_out_r <= dcs_out_nxt;
         sleep_r <= sleep_nxt;
         for (int i = 0; i < PIPE_DEPTH; i++) begin
            pipe_r[i] <= pipe_nxt[i];
         end
      end
   end

   // ****************************************
   // Link outputs
   // ****************************************
   // run_r moves while conv_clk is high, so gating cannot glitch
   assign data_ready_strobe = run_r & ~conv_clk; // [R05] [R04] [R08]
   assign sample_output_bus = bus_r; // [R03]
   assign duty_cycle_stabilizer = dcs_out_r; // [R06]

   // ****************************************
   // Status back into the system domain
   // ****************************************
   logic [1:0] stat_s;
   logic tog_seen_r;
   logic tog_seen_nxt;
   logic evt_r;
   logic evt_nxt;
   logic pdn_r;
   logic pdn_nxt;

   adcpo_sync #(.W(2)) u_stat_sync (
      .clock(clock),
      .nrst(nrst),
      .d({sleep_r, tog_r}),
      .q(stat_s)
   );

   always_comb begin
      tog_seen_nxt = stat_s[0];
      evt_nxt = stat_s[0] ^ tog_seen_r;
      pdn_nxt = stat_s[1];
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tog_seen_r <= 1'b0;
         evt_r <= 1'b0;
         pdn_r <= 1'b0;
      end else begin
         tog_seen_r <= tog_seen_nxt;
         evt_r <= evt_nxt;
         pdn_r <= pdn_nxt;
      end
   end

   assign range_event = evt_r;
   assign powered_down = pdn_r;
endmodule

// ---- tb/adcpo_top_props.sv ----
`timescale 1ns/1ps
module adcpo_top_props #(
   parameter int AIN_W = 14,
   parameter int DATA_W = 12,
   parameter int PIPE_DEPTH = 3
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic conv_clk,
   input wire logic power_down_select,
   input wire logic [1:0] format_stabilizer_select,
   input wire logic signed [AIN_W-1:0] analog_in,
   input wire logic [DATA_W-1:0] sample_output_bus,
   input wire logic data_ready_strobe,
   input wire logic duty_cycle_stabilizer,
   input wire logic powered_down,
   input wire logic range_event
);
   // ****
   // Helpers
   // ****
   localparam int PD_MAX = 30;
   logic [DATA_W-1:0] bus_fall_r;
   logic [3:0] conv_cnt_r;
   logic [4:0] sel_cnt_r;
   // Bus seen at strobe rise must still stand at the next conv edge
   always_ff @(negedge conv_clk or negedge nrst) begin
      if (!nrst) bus_fall_r <= '0;
      else bus_fall_r <= sample_output_bus;
   end
   always_ff @(posedge conv_clk or negedge nrst) begin
      if (!nrst) conv_cnt_r <= 4'h0;
      else if (conv_cnt_r != 4'hf) conv_cnt_r <= conv_cnt_r + 4'h1;
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) sel_cnt_r <= 5'h00;
      else if ($changed(format_stabilizer_select)) sel_cnt_r <= 5'h00;
      else if (sel_cnt_r != 5'h1f) sel_cnt_r <= sel_cnt_r + 5'h01;
   end
   sequence pd_enter_s;
      $rose(power_down_select);
   endsequence
   sequence pd_leave_s;
      $fell(power_down_select);
   endsequence
   // ****
   // Properties
   // ****
   AST_PD_ENTER: assert property (
      @(posedge clock) disable iff (!nrst)
      pd_enter_s |-> ##[1:PD_MAX] powered_down)
      else $error("Power-down not reached");
   AST_PD_LEAVE: assert property (
      @(posedge clock) disable iff (!nrst)
      pd_leave_s |-> ##[1:PD_MAX] !powered_down)
      else $error("Power-down not left");
   AST_PD_QUIET: assert property (
      @(posedge clock) disable iff (!nrst)
      powered_down && power_down_select |->
      sample_output_bus == '0 && !data_ready_strobe)
      else $error("Output active in power-down");
   AST_STROBE_PHASE: assert property (
      @(negedge conv_clk) disable iff (!nrst)
      conv_clk |-> !data_ready_strobe)
      else $error("Strobe high while conv clock high");
   AST_BUS_HOLD: assert property (
      @(posedge conv_clk) disable iff (!nrst)
      sample_output_bus == bus_fall_r)
      else $error("Bus moved away from strobe fall");
   AST_STROBE_RUNS: assert property (
      @(posedge conv_clk) disable iff (!nrst)
      data_ready_strobe && !power_down_select |=> data_ready_strobe)
      else $error("Strobe missed a cycle");
   AST_WAKE_QUIET: assert property (
      @(posedge conv_clk) disable iff (!nrst)
      conv_cnt_r < PIPE_DEPTH |-> !data_ready_strobe)
      else $error("Strobe before pipeline flush");
   AST_DCS: assert property (
      @(posedge clock) disable iff (!nrst)
      sel_cnt_r == 5'h14 |-> duty_cycle_stabilizer ==
      (format_stabilizer_select == 2'h1 || format_stabilizer_select == 2'h2))
      else $error("Stabilizer status wrong");
endmodule

// ---- tb/adcpo_capture.sv ----
`timescale 1ns/1ps
module adcpo_capture (
   input wire logic nrst,
   input wire logic data_ready_strobe,
   input wire logic [11:0] sample_output_bus,
   output logic [11:0] cap_word,
   output int unsigned n_cap
);
   always @(posedge data_ready_strobe or negedge nrst) begin
      if (!nrst) begin
         cap_word <= 12'h000;
         n_cap <= 0;
      end else begin
         cap_word <= sample_output_bus;
         n_cap <= n_cap + 1;
      end
   end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "adcpo_cfg.svh"
module tb_top;
   // Word sampled at one rise reaches the bus PIPE_DEPTH rises later
   localparam int LAT = `ADCPO_PIPE_DEPTH;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic conv_clk = 1'b0;
   logic power_down_select = 1'b0;
   logic [1:0] format_stabilizer_select = 2'h0;
   logic signed [13:0] analog_in = 14'h0000;
   logic [11:0] sample_output_bus, cap_word;
   logic data_ready_strobe, duty_cycle_stabilizer, powered_down, range_event;
   logic twos = 1'b0;
   logic chk_en = 1'b0;
   int unsigned n_cap, last_cap = 0, n_rise = 0, r0, c0;
   int miscompares = 0;
   int n_compared = 0;
   int streak = 0;
   int unsigned n_evt = 0, e0;
   logic signed [13:0] hist[$];
   // Range edges and full-scale extremes
   logic signed [13:0] corners[6] = '{14'h2000, 14'h37ff, 14'h3800,
      14'h07ff, 14'h0800, 14'h1fff};

   always #10 clock = ~clock;
   // Odd offset keeps the two clocks from ever sharing an edge
   initial begin
      #3;
      forever #6 conv_clk = ~conv_clk;
   end

   adcpo_top #(.PIPE_DEPTH(`ADCPO_PIPE_DEPTH)) DUT (
      .clock(clock), .nrst(nrst), .conv_clk(conv_clk),
      .power_down_select(power_down_select),
      .format_stabilizer_select(format_stabilizer_select),
      .analog_in(analog_in), .sample_output_bus(sample_output_bus),
      .data_ready_strobe(data_ready_strobe),
      .duty_cycle_stabilizer(duty_cycle_stabilizer),
      .powered_down(powered_down), .range_event(range_event));
   adcpo_capture u_cap (.nrst(nrst), .data_ready_strobe(data_ready_strobe),
      .sample_output_bus(sample_output_bus), .cap_word(cap_word),
      .n_cap(n_cap));

   function automatic logic [11:0] exp_word(logic signed [13:0] s,
      logic tc);
      int v;
      logic [11:0] w;
      v = int'(s) + 2048;
      w = (v < 0) ? 12'h000 : (v > 4095) ? 12'hfff : 12'(v);
      return tc ? {~w[11], w[10:0]} : w;
   endfunction

   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic wait_pd(logic lvl);
      int t;
      t = 0;
      while (powered_down !== lvl && t < 100) begin
         @(posedge clock);
         t++;
      end
      check("power-down status", 32'(lvl), 32'(powered_down));
      if (t >= 100) end_of_test();
   endtask

   always @(posedge clock) begin
      if (range_event === 1'b1) n_evt <= n_evt + 1;
   end

   // ****
   // Link stimulus and word checking
   // ****
   always @(posedge conv_clk) begin
      streak = (n_cap != last_cap) ? streak + 1 : 0;
      last_cap = n_cap;
      if (chk_en && streak > LAT + 1)
         check("word", exp_word(hist[hist.size() - 1 - LAT], twos),
            cap_word);
      hist.push_back(analog_in);
      n_rise++;
      analog_in <= (n_rise % 3 == 0) ? corners[(n_rise / 3) % 6]
         : 14'($urandom);
   end

   // ****
   // Main sequence
   // ****
   initial begin
      void'($urandom(70));
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         chk_en <= 1'b0;
         format_stabilizer_select <= adcpo_pkg::adcpo_level_t'(i);
         twos <= (i >= 2);
         repeat (30) @(posedge clock);
         chk_en <= 1'b1;
         e0 = n_evt;
         repeat (300) @(posedge clock);
         check("range events", 1, 32'(n_evt > e0));
         check("stabilizer", 32'(i == 1 || i == 2),
            32'(duty_cycle_stabilizer));
         $display("Format test %0d done", i);
      end
      r0 = n_rise;
      c0 = n_cap;
      repeat (100) @(posedge clock);
      check("strobe rate", 1,
         32'((n_rise - r0) - (n_cap - c0) + 1 <= 2));
      $display("Rate test done");
      chk_en <= 1'b0;
      power_down_select <= 1'b1;
      wait_pd(1'b1);
      repeat (2) @(posedge clock);
      c0 = n_cap;
      e0 = n_evt;
      repeat (50) @(posedge clock);
      check("events in power-down", e0, n_evt);
      check("strobes in power-down", c0, n_cap);
      check("bus in power-down", 0, 32'(sample_output_bus));
      power_down_select <= 1'b0;
      wait_pd(1'b0);
      repeat (30) @(posedge clock);
      chk_en <= 1'b1;
      repeat (100) @(posedge clock);
      check("strobes after wake", 1, 32'(n_cap - c0 > 100));
      $display("Power-down test done");
      end_of_test();
   end
endmodule

bind adcpo_top adcpo_top_props #(.AIN_W(AIN_W), .DATA_W(DATA_W),
   .PIPE_DEPTH(PIPE_DEPTH)) u_props (.clock(clock), .nrst(nrst),
   .conv_clk(conv_clk), .power_down_select(power_down_select),
   .format_stabilizer_select(format_stabilizer_select),
   .analog_in(analog_in), .sample_output_bus(sample_output_bus),
   .data_ready_strobe(data_ready_strobe),
   .duty_cycle_stabilizer(duty_cycle_stabilizer),
   .powered_down(powered_down), .range_event(range_event));
